// file: logic/prio_pkg.sv
// Purpose: shared constants and types of the priority control
// Assumes: 100 MHz clock, twelve-bit addresses
// Notes: address map and order code values are local choices
package prio_pkg;
    localparam int ADDR_W = 12;
    localparam int NUM_INT_DEF = 10;
    localparam int NUM_CNT_DEF = 29;
    localparam int CLK_KHZ = 100_000;
    localparam int INT_LOCK_MS = 30;
    localparam int INT_LOCK_CYC_DEF = INT_LOCK_MS * CLK_KHZ;
    localparam logic [ADDR_W-1:0] START_ADDR = 12'h800;
    localparam logic [ADDR_W-1:0] INT_BASE = 12'h804;
    localparam logic [ADDR_W-1:0] INT_STEP = 12'h004;
    localparam logic [ADDR_W-1:0] CNT_BASE = 12'h024;
    localparam logic [ADDR_W-1:0] CNT_STEP = 12'h001;
    localparam logic RESET_ZERO = 1'b0;
    typedef enum logic [1:0] {
        ORD_NONE = 2'h0,
        ORD_START = 2'h1,
        ORD_INT = 2'h2,
        ORD_CNT = 2'h3
    } order_t;
endpackage

// file: logic/cnt_if.sv
// Purpose: link between the priority core and the counter arbiter
// Assumes: single clock domain
// Notes: ctl side is the core, arb side is the arbiter
`timescale 1ns/1ps
`default_nettype none
interface cnt_if #(parameter int NUM = 29);
    logic [NUM-1:0] pulse;
    logic take;
    logic clear;
    logic req_any;
    logic [4:0] req_idx;
    logic alarm;
    modport ctl (output pulse, output take, output clear,
                 input req_any, input req_idx, input alarm);
    modport arb (input pulse, input take, input clear,
                 output req_any, output req_idx, output alarm);
endinterface
`default_nettype wire

// file: logic/counter_arbiter.sv
// Purpose: pending incremental requests, fixed priority, lost-pulse alarm
// Assumes: pulses are one cycle wide and synchronous
// Notes: lowest index wins
`timescale 1ns/1ps
`default_nettype none
module counter_arbiter
    import prio_pkg::*;
#(
    parameter int NUM = NUM_CNT_DEF
) (
    input wire logic clk_i,
    input wire logic rst_i,
    cnt_if.arb link
);
    generate
        if (NUM < 1 || NUM > 32) begin : g_bad
            $error("counter_arbiter: NUM must be 1..32");
        end
    endgenerate

    function automatic logic [4:0] first_set(input logic [NUM-1:0] v);
        logic [4:0] r;
        r = 5'h00;
        for (int i = NUM - 1; i >= 0; i--) begin
            if (v[i]) begin
                r = 5'(i);
            end
        end
        return r;
    endfunction

    logic [NUM-1:0] pending_q;
    logic [4:0] lock_q;
    logic locked_q;
    logic alarm_q;
    logic [NUM-1:0] clr_vec;
    logic [NUM-1:0] lost;

    always_comb begin
        clr_vec = '0;
        if (link.clear && locked_q) begin
            clr_vec[lock_q] = 1'b1;
        end
    end

    assign lost = link.pulse & pending_q & ~clr_vec;

    // ====================================================================
    // Pending flags
    // capture incremental pulses
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pending_q <= '0;
        end else begin
            // Set wins so an increment landing on its own clear is kept
            pending_q <= (pending_q & ~clr_vec) | link.pulse;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            locked_q <= RESET_ZERO;
            lock_q <= 5'h00;
        end else if (link.take) begin
            locked_q <= 1'b1;
            lock_q <= first_set(pending_q);
        end else if (link.clear) begin
            locked_q <= RESET_ZERO;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            alarm_q <= RESET_ZERO;
        end else begin
            alarm_q <= |lost;
        end
    end

    assign link.req_any = |pending_q;
    assign link.req_idx = first_set(pending_q);
    assign link.alarm = alarm_q;

    // ====================================================================
    // Checks
    a_cnt_alarm: assert property (@(posedge clk_i) disable iff (rst_i)
        (|lost) |=> alarm_q) else $error("lost increment not flagged");
    a_cnt_priority: assert property (@(posedge clk_i) disable iff (rst_i)
        link.req_any |-> ((pending_q & ((NUM'(1) << link.req_idx) - NUM'(1))) == '0))
        else $error("counter priority violated");
    c_cnt_alarm: cover property (@(posedge clk_i) disable iff (rst_i) alarm_q);
endmodule
`default_nettype wire

// file: logic/priority_control.sv
// Purpose: forces start, interrupt and counter instructions
// Assumes: inputs synchronous to CLOCK_I, one-cycle request pulses
// Notes: start outranks counter, counter outranks interrupt
//
// Function
// - Every forced instruction sends an order code and a 12-bit address; all but the start entered at reset also send the instruction signal.
// - Start is forced on a program trap, a power transient or a stuck interrupt service.
// - The start order code forces the start instruction and resets other circuits.
// - While start is issued the time pulse generator is stopped until start is forced.
// - Monitor stop forces start and holds the time pulses at the final position until start is forced after its release.
// - An interrupt sends the interrupt order code and its matching address.
// - Exactly ten interrupt addresses exist, one per regulated function.
// - The address reaches the processor only on read control pulses.
// - A fixed chain serves interrupts in turn, advanced by the returned decoded address.
// - Counter requests delay the program through a counter instruction, never interrupt it.
// - Twenty-nine counter addresses are arbitrated with a fixed priority.
// - An alarm is raised when an incremental pulse is not processed properly.
// - Incremental inputs are taken in and turned into counter updates.
// - Keyboard, telemetry and time counter events arrive as interrupt requests.
// - Standby holds the restart condition with switched supplies off.
// - Interrupt and counter grants are sequenced by the memory-cycle time pulses; start outputs and the stop request follow at the next clock.
`timescale 1ns/1ps
`default_nettype none
module priority_control
    import prio_pkg::*;
#(
    parameter int NUM_INT = NUM_INT_DEF,
    parameter int NUM_CNT = NUM_CNT_DEF,
    parameter int INT_LOCK_CYC = INT_LOCK_CYC_DEF
) (
    input wire logic CLOCK_I,
    input wire logic RST_I,
    input wire logic TRAP_I,
    input wire logic POWER_FAIL_I,
    input wire logic STANDBY_I,
    input wire logic MONITOR_STOP_I,
    input wire logic [NUM_INT-1:0] INT_REQ_I,
    input wire logic [NUM_CNT-1:0] CNT_PULSE_I,
    input wire logic BOUNDARY_I,
    input wire logic FINAL_TP_I,
    input wire logic START_DONE_I,
    input wire logic READ_PULSE_I,
    input wire logic DEC_VALID_I,
    input wire logic [ADDR_W-1:0] DEC_ADDR_I,
    output logic [1:0] ORDER_CODE_O,
    output logic INSTR_O,
    output logic [ADDR_W-1:0] ADDR_O,
    output logic ADDR_WRITE_O,
    output logic TP_STOP_O,
    output logic RESET_CIRCUITS_O,
    output logic ALARM_O,
    output logic SUPPLY_ON_O
);
    generate
        if (NUM_INT < 1 || NUM_INT > 16 || NUM_CNT < 1 || NUM_CNT > 32
            || INT_LOCK_CYC < 2 || INT_LOCK_CYC > (1 << 23)) begin : g_bad
            $error("priority_control: unsupported parameters");
        end
    endgenerate

    typedef enum logic [3:0] {
        ST_RUN = 4'b0001,
        ST_INT = 4'b0010,
        ST_CNT = 4'b0100,
        ST_START = 4'b1000
    } state_t;

    function automatic logic [3:0] first_int(input logic [NUM_INT-1:0] v);
        logic [3:0] r;
        r = 4'h0;
        for (int i = NUM_INT - 1; i >= 0; i--) begin
            if (v[i]) begin
                r = 4'(i);
            end
        end
        return r;
    endfunction

    state_t state_q, state_d;
    logic [NUM_INT-1:0] int_pend_q;
    logic [3:0] int_idx_q;
    logic [ADDR_W-1:0] addr_d;
    logic [22:0] lock_cnt_q;
    logic malf_q;
    logic start_cause;
    logic dec_match;
    logic at_edge;
    logic [NUM_INT-1:0] int_clr;

    cnt_if #(.NUM(NUM_CNT)) cnt ();

    counter_arbiter #(.NUM(NUM_CNT)) u_cnt (
        .clk_i(CLOCK_I),
        .rst_i(RST_I),
        .link(cnt.arb)
    );

    // ====================================================================
    // Causes and handshakes
    // start causes
    assign start_cause = TRAP_I | POWER_FAIL_I | malf_q | STANDBY_I | MONITOR_STOP_I;
    assign at_edge = BOUNDARY_I & FINAL_TP_I;
    assign dec_match = DEC_VALID_I & (DEC_ADDR_I == ADDR_O);
    assign cnt.pulse = CNT_PULSE_I;
    assign cnt.take = (state_d == ST_CNT) && (state_q != ST_CNT);
    assign cnt.clear = (state_q == ST_CNT) && dec_match;

    always_comb begin
        int_clr = '0;
        if (state_q == ST_INT && dec_match) begin
            int_clr[int_idx_q] = 1'b1;
        end
    end

    // ====================================================================
    // Interrupt pending flags
    // requests from input-output
    always_ff @(posedge CLOCK_I) begin
        if (RST_I) begin
            int_pend_q <= '0;
        end else begin
            // Set wins over the clear so a request landing on its own clear is kept
            int_pend_q <= (int_pend_q & ~int_clr) | INT_REQ_I;
        end
    end

    // ====================================================================
    // Next state
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_RUN: begin
                if (cnt.req_any && at_edge) begin
                    state_d = ST_CNT;
                end else if ((|int_pend_q) && at_edge) begin
                    state_d = ST_INT;
                end
            end
            ST_INT: begin
                if (dec_match) begin
                    state_d = ST_RUN;
                end
            end
            ST_CNT: begin
                if (dec_match) begin
                    state_d = ST_RUN;
                end
            end
            ST_START: begin
                if (START_DONE_I && !start_cause) begin
                    state_d = ST_RUN;
                end
            end
        endcase
        if (start_cause) begin
            state_d = ST_START;
        end
    end

    always_ff @(posedge CLOCK_I) begin
        if (RST_I) begin
            state_q <= ST_START;
        end else begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge CLOCK_I) begin
        if (RST_I) begin
            int_idx_q <= 4'h0;
        end else if (state_d == ST_INT && state_q != ST_INT) begin
            int_idx_q <= first_int(int_pend_q);
        end
    end

    // ====================================================================
    // Stuck interrupt watchdog
    // interrupt malfunction
    always_ff @(posedge CLOCK_I) begin
        if (RST_I) begin
            lock_cnt_q <= 23'h00_0000;
            malf_q <= RESET_ZERO;
        end else begin
            malf_q <= (state_q == ST_INT) && (lock_cnt_q == 23'(INT_LOCK_CYC - 2));
            if (state_q == ST_INT) begin
                lock_cnt_q <= lock_cnt_q + 23'h00_0001;
            end else begin
                lock_cnt_q <= 23'h00_0000;
            end
        end
    end

    // ====================================================================
    // Forced address
    // matching interrupt address
    always_comb begin
        addr_d = ADDR_O;
        if (state_d == ST_START) begin
            addr_d = START_ADDR;
        end else if (state_d == ST_INT && state_q != ST_INT) begin
            addr_d = ADDR_W'(INT_BASE + ADDR_W'(first_int(int_pend_q)) * INT_STEP);
        end else if (state_d == ST_CNT && state_q != ST_CNT) begin
            addr_d = ADDR_W'(CNT_BASE + ADDR_W'(cnt.req_idx) * CNT_STEP);
        end
    end

    // ====================================================================
    // Outputs to sequence generator and processor
    // order code, instruction, address
    always_ff @(posedge CLOCK_I) begin
        if (RST_I) begin
            ORDER_CODE_O <= ORD_START;
            INSTR_O <= RESET_ZERO;
            ADDR_O <= START_ADDR;
        end else begin
            INSTR_O <= (state_d != ST_RUN) && (state_d != state_q);
            ADDR_O <= addr_d;
            unique case (state_d)
                ST_RUN: ORDER_CODE_O <= ORD_NONE;
                ST_INT: ORDER_CODE_O <= ORD_INT;
                ST_CNT: ORDER_CODE_O <= ORD_CNT;
                ST_START: ORDER_CODE_O <= ORD_START;
            endcase
        end
    end

    always_ff @(posedge CLOCK_I) begin
        if (RST_I) begin
            ADDR_WRITE_O <= RESET_ZERO;
        end else begin
            ADDR_WRITE_O <= READ_PULSE_I && (state_q != ST_RUN);
        end
    end

    always_ff @(posedge CLOCK_I) begin
        if (RST_I) begin
            TP_STOP_O <= 1'b1;
            RESET_CIRCUITS_O <= 1'b1;
            SUPPLY_ON_O <= RESET_ZERO;
            ALARM_O <= RESET_ZERO;
        end else begin
            TP_STOP_O <= (state_d == ST_START) || MONITOR_STOP_I;
            RESET_CIRCUITS_O <= (state_d == ST_START);
            SUPPLY_ON_O <= !STANDBY_I;
            ALARM_O <= cnt.alarm;
        end
    end

    // ====================================================================
    // Checks
    a_start_outputs: assert property (@(posedge CLOCK_I) disable iff (RST_I)
        state_q == ST_START |-> ORDER_CODE_O == ORD_START && RESET_CIRCUITS_O && TP_STOP_O)
        else $error("start outputs wrong");
    a_trap_start: assert property (@(posedge CLOCK_I) disable iff (RST_I)
        TRAP_I |=> state_q == ST_START && ADDR_O == START_ADDR)
        else $error("trap did not force start");
    a_monitor_hold: assert property (@(posedge CLOCK_I) disable iff (RST_I)
        MONITOR_STOP_I |=> TP_STOP_O) else $error("monitor stop not held");
    a_addr_gate: assert property (@(posedge CLOCK_I) disable iff (RST_I)
        ADDR_WRITE_O |-> $past(READ_PULSE_I)) else $error("address written without read");
    a_grant_edge: assert property (@(posedge CLOCK_I) disable iff (RST_I)
        (state_q inside {ST_INT, ST_CNT}) && $past(state_q) == ST_RUN
        |-> $past(at_edge)) else $error("grant off boundary");
    a_instr_pulse: assert property (@(posedge CLOCK_I) disable iff (RST_I)
        INSTR_O |-> ORDER_CODE_O != ORD_NONE ##1 !INSTR_O)
        else $error("instruction signal malformed");
    a_int_range: assert property (@(posedge CLOCK_I) disable iff (RST_I)
        state_q == ST_INT |-> ADDR_O >= INT_BASE
        && ADDR_O < ADDR_W'(INT_BASE + ADDR_W'(NUM_INT) * INT_STEP))
        else $error("interrupt address out of range");
    a_standby_off: assert property (@(posedge CLOCK_I) disable iff (RST_I)
        STANDBY_I |=> !SUPPLY_ON_O && state_q == ST_START)
        else $error("standby not honoured");
    a_int_release: assert property (@(posedge CLOCK_I) disable iff (RST_I)
        state_q == ST_INT && dec_match |=> state_q != ST_INT)
        else $error("interrupt not released");
    a_cnt_resume: assert property (@(posedge CLOCK_I) disable iff (RST_I)
        state_q == ST_CNT && dec_match && !start_cause |=> state_q == ST_RUN)
        else $error("counter did not resume program");
    c_int_served: cover property (@(posedge CLOCK_I) disable iff (RST_I)
        state_q == ST_INT ##[1:20] state_q == ST_RUN);
    c_cnt_served: cover property (@(posedge CLOCK_I) disable iff (RST_I)
        state_q == ST_CNT ##[1:20] state_q == ST_RUN);
    c_start_done: cover property (@(posedge CLOCK_I) disable iff (RST_I)
        state_q == ST_START ##1 state_q == ST_RUN);
endmodule
`default_nettype wire

// file: verification/seq_model.sv
// Purpose: far-side model of timer and sequence generator
// Assumes: one clock, replies change just after a rising edge
// Notes: slow_i stretches replies, hang_i withholds the decode
`timescale 1ns/1ps
`default_nettype none
module seq_model
    import prio_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic slow_i,
    input wire logic hang_i,
    input wire logic [1:0] order_i,
    input wire logic instr_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic tp_stop_i,
    output logic boundary_o,
    output logic final_tp_o,
    output logic start_done_o,
    output logic read_o,
    output logic dec_valid_o,
    output logic [ADDR_W-1:0] dec_addr_o
);
    logic [1:0] tp_q;
    logic [3:0] wait_q;
    logic [3:0] dly;
    logic [ADDR_W-1:0] lat_q;
    logic forced;
    // =========================================
    // Time pulses
    // held at final pulse
    always_ff @(posedge clk_i) begin
        if (rst_i || tp_stop_i) begin
            tp_q <= 2'h3;
        end else begin
            tp_q <= tp_q + 2'h1;
        end
    end
    assign final_tp_o = (tp_q == 2'h3);
    // =========================================
    // Replies
    assign dly = slow_i ? 4'h9 : 4'h2;
    assign forced = (order_i == ORD_INT) || (order_i == ORD_CNT);
    assign boundary_o = (order_i == ORD_NONE);
    always_ff @(posedge clk_i) begin
        if (rst_i || instr_i || order_i == ORD_NONE) begin
            wait_q <= 4'h0;
        end else if (wait_q != 4'hf) begin
            wait_q <= wait_q + 4'h1;
        end
    end
    // start forced after a delay
    // A count left over from an earlier forced instruction must not finish a new start
    assign start_done_o = (order_i == ORD_START) && !instr_i && (wait_q >= dly);
    assign read_o = forced && (wait_q == dly);
    assign dec_valid_o = forced && !hang_i && (wait_q == dly + 4'h1);
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            lat_q <= 12'h000;
        end else if (read_o) begin
            lat_q <= addr_i;
        end
    end
    // Inverse when invalid so a stale address never looks valid
    assign dec_addr_o = dec_valid_o ? lat_q : ~lat_q;
endmodule
`default_nettype wire

// file: verification/priority_control_tb.sv
// Purpose: self-checking bench of the priority control
// Assumes: inputs driven at the falling edge
// Notes: lock count shortened to 20 cycles
`timescale 1ns/1ps
`default_nettype none
module priority_control_tb;
    import prio_pkg::*;
    localparam int LOCK = 20;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic trap = 1'b0;
    logic pfail = 1'b0;
    logic stby = 1'b0;
    logic mon = 1'b0;
    logic slow = 1'b0;
    logic hang = 1'b0;
    logic [9:0] int_req = 10'h000;
    logic [28:0] cnt_pulse = 29'h0000_0000;
    logic bnd, ftp, sdone, rdp, dval, instr, awr, tps, rc, alarm, sup;
    logic [ADDR_W-1:0] daddr;
    logic [ADDR_W-1:0] addr;
    logic [1:0] order;
    int fail_count = 0;
    int n_checks = 0;
    int cycles = 0;
    int wr;

    always #5 clk = ~clk;

    priority_control #(.INT_LOCK_CYC(LOCK)) uut (
        .CLOCK_I(clk), .RST_I(rst), .TRAP_I(trap), .POWER_FAIL_I(pfail),
        .STANDBY_I(stby), .MONITOR_STOP_I(mon), .INT_REQ_I(int_req),
        .CNT_PULSE_I(cnt_pulse), .BOUNDARY_I(bnd), .FINAL_TP_I(ftp),
        .START_DONE_I(sdone), .READ_PULSE_I(rdp), .DEC_VALID_I(dval),
        .DEC_ADDR_I(daddr), .ORDER_CODE_O(order), .INSTR_O(instr),
        .ADDR_O(addr), .ADDR_WRITE_O(awr), .TP_STOP_O(tps),
        .RESET_CIRCUITS_O(rc), .ALARM_O(alarm), .SUPPLY_ON_O(sup)
    );

    seq_model far (
        .clk_i(clk), .rst_i(rst), .slow_i(slow), .hang_i(hang),
        .order_i(order), .instr_i(instr), .addr_i(addr), .tp_stop_i(tps),
        .boundary_o(bnd), .final_tp_o(ftp), .start_done_o(sdone),
        .read_o(rdp), .dec_valid_o(dval), .dec_addr_o(daddr)
    );

    // =========================================
    // Shared tasks
    task automatic check(input string what, input logic [11:0] exp, input logic [11:0] got);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic wait_idle(output int w);
        int n;
        n = 0;
        w = 0;
        while (order !== 2'h0 && n < 200) begin
            @(negedge clk);
            w += int'(awr === 1'b1);
            n++;
        end
        check("idle order", 12'h000, {10'h000, order});
    endtask

    task automatic serve(input logic [1:0] eo, input logic [ADDR_W-1:0] ea);
        int n;
        int w;
        n = 0;
        while (instr !== 1'b1 && n < 200) begin
            @(negedge clk);
            n++;
        end
        check("order", {10'h000, eo}, {10'h000, order});
        check("addr", ea, addr);
        wait_idle(w);
        check("addr writes", 12'h001, 12'(w));
    endtask

    // =========================================
    // Scenarios
    task automatic t_reset();
        check("rst order", 12'h001, {10'h000, order});
        check("rst addr", START_ADDR, addr);
        check("rst stop", 12'h001, {11'h000, tps});
        check("rst supply", 12'h000, {11'h000, sup});
        rst = 1'b0;
        wait_idle(wr);
        check("run stop", 12'h000, {11'h000, tps});
        check("run supply", 12'h001, {11'h000, sup});
        $display("test reset done");
    endtask

    task automatic t_ints();
        for (int i = 0; i < 10; i++) begin
            int_req[i] = 1'b1;
            @(negedge clk);
            int_req = 10'h000;
            serve(ORD_INT, INT_BASE + INT_STEP * 12'(i));
        end
        $display("test interrupts done");
    endtask

    task automatic t_prio();
        slow = 1'b1;
        int_req = 10'h088;
        cnt_pulse = 29'h1000_0020;
        @(negedge clk);
        int_req = 10'h000;
        cnt_pulse = 29'h0000_0000;
        serve(ORD_CNT, CNT_BASE + 12'h005);
        serve(ORD_CNT, CNT_BASE + 12'h01c);
        serve(ORD_INT, INT_BASE + 12'h00c);
        serve(ORD_INT, INT_BASE + 12'h01c);
        slow = 1'b0;
        $display("test priority done");
    endtask

    task automatic t_alarm();
        int a;
        a = 0;
        slow = 1'b1;
        for (int c = 0; c < 8; c++) begin
            cnt_pulse[2] = (c == 0 || c == 2);
            @(negedge clk);
            a += int'(alarm === 1'b1);
        end
        check("alarms", 12'h001, 12'(a));
        wait_idle(wr);
        slow = 1'b0;
        $display("test alarm done");
    endtask

    task automatic t_start();
        for (int k = 0; k < 4; k++) begin
            {mon, stby, pfail, trap} = 4'(1 << k);
            repeat (3) @(negedge clk);
            check("start order", 12'h001, {10'h000, order});
            check("start stop", 12'h001, {11'h000, tps});
            check("start resets", 12'h001, {11'h000, rc});
            check("start addr", START_ADDR, addr);
            check("supply", {11'h000, k != 2}, {11'h000, sup});
            repeat (12) @(negedge clk);
            check("held", 12'h001, {10'h000, order});
            {mon, stby, pfail, trap} = 4'h0;
            wait_idle(wr);
            check("stop off", 12'h000, {11'h000, tps});
        end
        $display("test start causes done");
    endtask

    task automatic t_lock();
        int n;
        n = 0;
        hang = 1'b1;
        int_req[0] = 1'b1;
        @(negedge clk);
        int_req = 10'h000;
        while (order !== 2'h1 && n < LOCK + 30) begin
            @(negedge clk);
            n++;
        end
        check("lock start", 12'h001, {10'h000, order});
        hang = 1'b0;
        repeat (40) @(negedge clk);
        wait_idle(wr);
        $display("test lock done");
    endtask

    // =========================================
    // Main sequence and timeout
    initial begin
        repeat (20) @(negedge clk);
        t_reset();
        t_ints();
        t_prio();
        t_alarm();
        t_start();
        t_lock();
        close_out();
    end

    // Whole run needs a few hundred cycles; the ceiling leaves ample margin
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            close_out();
        end
    end
endmodule
`default_nettype wire
